//--- design/gate_driver_fault_manager.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
module gate_driver_fault_manager import fault_mgr_pkg::*; #(
	parameter int RETRY_CYCLES = OC_RETRY_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire monitor_t monitors,
	input wire logic enable_pin,
	output logic fault_pin_n_o,
	output logic fault_pin_n_oe,
	output logic gate_inputs_block,
	output logic gate_outputs_hiz,
	output logic standby_regulator_en,
	output logic microcontroller_regulator_low_power,
	output logic logic_regulator_en,
	output logic pump_en,
	output logic pump_hiz,
	output logic buck_en,
	output logic buck_hiz,
	output logic buck_hiccup,
	output logic buck_current_limit_en,
	output mode_t mode,
	output logic irq
);
	// ==========================================
	// Input synchronisation
	monitor_t mon;
	logic en_s;
	logic en_d_q;
	sync2 #(.W($bits(monitor_t) + 1)) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.d({monitors, enable_pin}),
		.q({mon, en_s})
	);

	// ==========================================
	// Register state
	ctrl_t ctrl_q;
	logic [NF-1:0] stat_q, stat_d, int_q, int_d, mask_q, hold_q, hold_d;
	logic [NF-1:0] pl_q, pl_d;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	mode_t mode_q, mode_d;

	// Bus decode
	wire acc = psel && penable;
	wire wr = acc && pwrite && pready_q;
	wire hit_ctrl = (paddr == OFF_CTRL);
	wire hit_stat = (paddr == OFF_STATUS);
	wire hit_int = (paddr == OFF_IRQ_STATUS);
	wire hit_mask = (paddr == OFF_IRQ_MASK);
	wire hit_mode = (paddr == OFF_MODE);
	wire hit_any = hit_ctrl | hit_stat | hit_int | hit_mask | hit_mode;
	wire ctrl_t wctl = ctrl_t'(pwdata[14:0]);

	// Clear event: enable rising edge or a written fault clear
	wire clr_wr = wr && hit_ctrl && wctl.fault_clear;
	wire clr = clr_wr || (en_s && !en_d_q);

	// ==========================================
	// Fault vector and per-fault configuration
	wire [NF-1:0] f = {mon.drive_rail_overvoltage, mon.drive_rail_undervoltage,
		mon.buck_overcurrent, mon.thermal_shutdown, mon.temperature_warning,
		mon.gate_stuck_fault, mon.sense_overcurrent, mon.drain_source_overcurrent,
		mon.pump_undervoltage, mon.motor_supply_overvoltage, mon.motor_supply_undervoltage};
	wire luv = mon.logic_supply_undervoltage;
	wire [1:0] dsm = ctrl_q.drain_source_oc_response;
	wire [1:0] scm = ctrl_q.sense_oc_response;

	// Reported faults set status; a disabled supply fault still reports
	wire [NF-1:0] rep = {5'h1f, ~ctrl_q.gate_stuck_detect_off, scm != OC_OFF,
		dsm != OC_OFF, 3'h7};

	// Faults whose response blocks the gate drivers
	wire [NF-1:0] act = {~ctrl_q.drive_rail_ov_off, ~ctrl_q.drive_rail_uv_off,
		~ctrl_q.buck_oc_detect_off, ~ctrl_q.thermal_shutdown_off, 1'b0,
		~ctrl_q.gate_stuck_detect_off, ~scm[1], ~dsm[1],
		~ctrl_q.pump_uv_detect_off, ~ctrl_q.motor_ov_detect_off,
		~ctrl_q.motor_uv_detect_off};

	wire [NF-1:0] fset = f & rep;
	wire [NF-1:0] fact = f & act;

	// Pin-latching faults and their retry mode
	wire [NF-1:0] latching = (NF'(1) << F_DSOC) | (NF'(1) << F_SOC) | (NF'(1) << F_STUCK);
	logic ds_exp, sc_exp;
	retry_timer #(.CYC(RETRY_CYCLES)) u_ds_retry (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(f[F_DSOC] && dsm == OC_RETRY),
		.expire(ds_exp)
	);
	retry_timer #(.CYC(RETRY_CYCLES)) u_sc_retry (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(f[F_SOC] && scm == OC_RETRY),
		.expire(sc_exp)
	);
	wire [NF-1:0] retry_rel = (NF'(ds_exp && dsm == OC_RETRY) << F_DSOC)
		| (NF'(sc_exp && scm == OC_RETRY) << F_SOC);

	// Latched recovery waits for soft-start on buck and rail undervoltage
	wire [NF-1:0] need_ss = (NF'(1) << F_BOC) | (NF'(1) << F_RUV);
	wire [NF-1:0] ss_ok = need_ss & {NF{~mon.soft_start_done}};
	wire [NF-1:0] rel = (~f & ~ss_ok & {NF{clr}}) | retry_rel;

	// Hold keeps the drivers blocked until recovery; motor undervoltage self-recovers
	always_comb begin
		hold_d = fact | (hold_q & ~rel);
		hold_d[F_MUV] = fact[F_MUV];
		pl_d = (fset & latching) | (pl_q & ~rel);
		stat_d = fset | (stat_q & ~{NF{clr}});
		stat_d[F_WARN] = f[F_WARN];
		int_d = (fset & ~stat_q) | (int_q & ~(wr && hit_int ? pwdata[NF-1:0] : '0));
	end

	// ==========================================
	// Fault pin: live reported faults, warning if routed, plus latches
	wire [NF-1:0] pin_live = fset & ~latching
		& ~(NF'(!ctrl_q.warning_to_pin) << F_WARN);
	wire pin_low = |pin_live | |pl_q;
	assign fault_pin_n_o = 1'b0;
	assign fault_pin_n_oe = pin_low && !luv;

	// ==========================================
	// Gate drive: any source may block (active-low enables ANDed)
	wire [NF-1:0] blk_n = ~(fact | hold_q);
	wire run = (mode_q == M_OPERATING) || (mode_q == M_FAULT);
	wire drv_ok = (&blk_n) && run && !luv;
	wire oc_only = ~|(~blk_n & ~((NF'(1) << F_DSOC) | (NF'(1) << F_SOC)));
	assign gate_inputs_block = !drv_ok;
	assign gate_outputs_hiz = !drv_ok && !(oc_only && run && ctrl_q.pulldown_select);

	// Regulators
	wire pwr_cut = luv | fact[F_MUV] | hold_q[F_MOV] | fact[F_MOV]
		| hold_q[F_TSD] | fact[F_TSD];
	wire rail_hz = fact[F_ROV] | hold_q[F_ROV];
	// Hiccup faults keep the standby regulator alive while the buck restarts
	assign standby_regulator_en = !run || pwr_cut || buck_hiccup;
	assign microcontroller_regulator_low_power = !en_s;
	assign logic_regulator_en = run && !pwr_cut;
	assign pump_en = run && !pwr_cut && !rail_hz;
	assign pump_hiz = rail_hz;
	assign buck_en = run && !pwr_cut && !rail_hz;
	assign buck_hiz = rail_hz;
	assign buck_hiccup = |(need_ss & (fact | hold_q));
	assign buck_current_limit_en = mon.buck_current_limit && !ctrl_q.buck_oc_detect_off;

	// ==========================================
	// Mode machine
	// Report-only faults keep the present mode; only a blocking fault changes it
	wire in_fault = !(&blk_n);
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			M_SHUTDOWN: mode_d = M_SLEEP;
			M_SLEEP: if (en_s) mode_d = M_OPERATING;
			M_OPERATING: begin
				if (!en_s) mode_d = M_SLEEP;
				else if (in_fault) mode_d = M_FAULT;
			end
			M_FAULT: begin
				if (!en_s) mode_d = M_SLEEP;
				else if (!in_fault) mode_d = M_OPERATING;
			end
			default: mode_d = M_SHUTDOWN;
		endcase
		if (luv) mode_d = M_SHUTDOWN;
	end
	assign mode = mode_q;

	// State registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_q <= M_SHUTDOWN;
			en_d_q <= 1'b0;
			stat_q <= '0;
			hold_q <= '0;
			pl_q <= '0;
			int_q <= '0;
		end else begin
			mode_q <= mode_d;
			en_d_q <= en_s;
			stat_q <= stat_d;
			hold_q <= hold_d;
			pl_q <= pl_d;
			int_q <= int_d;
		end
	end

	// ==========================================
	// APB slave: one wait state so read data comes from a flip-flop
	wire [NF:0] stat_full = {|stat_q, stat_q};
	wire [31:0] rd_mux = hit_ctrl ? {17'h0, ctrl_q[14:1], 1'b0}
		: hit_stat ? {20'h0, stat_full}
		: hit_int ? {21'h0, int_q}
		: hit_mask ? {21'h0, mask_q}
		: hit_mode ? {28'h0, mode_q} : 32'h0;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= acc && !pready_q;
			pslverr_q <= acc && !pready_q && !hit_any;
			if (acc && !pready_q) begin
				prdata_q <= pwrite ? 32'h0 : rd_mux;
			end
		end
	end
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// Software registers; fault clear never stores
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_q <= ctrl_t'(CTRL_RST);
			mask_q <= MASK_RST;
		end else begin
			if (wr && hit_ctrl) ctrl_q <= ctrl_t'({pwdata[14:1], 1'b0});
			if (wr && hit_mask) mask_q <= pwdata[NF-1:0];
		end
	end
	assign irq = |(int_q & mask_q);

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	luv_silent_a: assert property (luv |-> !fault_pin_n_oe && gate_inputs_block
		&& standby_regulator_en) else $error("logic undervoltage not silent");
	luv_sleep_a: assert property (mode_q == M_SHUTDOWN && !luv |=> mode_q == M_SLEEP)
		else $error("recovery skipped sleep");
	motor_fault_a: assert property (fact[F_MOV] && !luv |-> fault_pin_n_oe
		&& gate_inputs_block && !logic_regulator_en) else $error("motor fault response");
	disabled_keep_a: assert property ($rose(f[F_TSD]) && ctrl_q.thermal_shutdown_off
		&& (&blk_n) |=> stat_q[F_TSD]) else $error("disabled fault not reported");
	pump_uv_a: assert property (fact[F_PUV] && run && !pwr_cut |-> gate_inputs_block
		&& logic_regulator_en && !standby_regulator_en) else $error("pump uv response");
	oc_latch_a: assert property ($rose(f[F_DSOC]) && dsm != OC_OFF ##1 !f[F_DSOC]
		&& !clr && !ds_exp |-> pl_q[F_DSOC]) else $error("oc latch lost");
	oc_off_a: assert property (scm == OC_OFF && !pl_q[F_SOC] |=> !pl_q[F_SOC])
		else $error("sense oc reported in off mode");
	warn_clear_a: assert property ($fell(f[F_WARN]) |-> !stat_d[F_WARN])
		else $error("warning did not self clear");
	global_or_a: assert property (stat_full[NF] == |stat_q)
		else $error("global bit mismatch");
	stat_sticky_a: assert property (stat_q[F_MOV] && !clr |=> stat_q[F_MOV])
		else $error("status cleared without clear");
	apb_wait_a: assert property (acc && !pready_q |=> pready)
		else $error("apb answer late");
	cover_fault_c: cover property (mode_q == M_OPERATING ##1 mode_q == M_FAULT);
	cover_recover_c: cover property (mode_q == M_FAULT ##1 mode_q == M_OPERATING);
	cover_retry_c: cover property (ds_exp && pl_q[F_DSOC]);
endmodule // gate_driver_fault_manager

//--- design/fault_mgr_pkg.sv
package fault_mgr_pkg;
	// ==========================================
	// Clock and timing
	localparam int CLK_MHZ = 250;
	localparam int OC_RETRY_US = 1000; // Overcurrent retry wait, plain default
	localparam int OC_RETRY_CYC = OC_RETRY_US * CLK_MHZ;
	// ==========================================
	// Fault indices in status, interrupt and mask registers
	localparam int NF = 11;
	localparam int F_MUV = 0;
	localparam int F_MOV = 1;
	localparam int F_PUV = 2;
	localparam int F_DSOC = 3;
	localparam int F_SOC = 4;
	localparam int F_STUCK = 5;
	localparam int F_WARN = 6;
	localparam int F_TSD = 7;
	localparam int F_BOC = 8;
	localparam int F_RUV = 9;
	localparam int F_ROV = 10;
	localparam int F_GLOBAL = 11;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;
	localparam logic [11:0] OFF_MODE = 12'h010;
	localparam logic [14:0] CTRL_RST = 15'h0000;
	localparam logic [10:0] MASK_RST = 11'h000;
	// ==========================================
	// Control register layout, bit 0 is the self-clearing fault clear
	typedef struct packed {
		logic [1:0] sense_oc_response;
		logic [1:0] drain_source_oc_response;
		logic pulldown_select;
		logic warning_to_pin;
		logic drive_rail_ov_off;
		logic drive_rail_uv_off;
		logic buck_oc_detect_off;
		logic thermal_shutdown_off;
		logic gate_stuck_detect_off;
		logic pump_uv_detect_off;
		logic motor_ov_detect_off;
		logic motor_uv_detect_off;
		logic fault_clear;
	} ctrl_t;
	// Monitor comparator outputs, bit 0 is motor undervoltage
	typedef struct packed {
		logic soft_start_done;
		logic logic_supply_undervoltage;
		logic buck_current_limit;
		logic drive_rail_overvoltage;
		logic drive_rail_undervoltage;
		logic buck_overcurrent;
		logic thermal_shutdown;
		logic temperature_warning;
		logic gate_stuck_fault;
		logic sense_overcurrent;
		logic drain_source_overcurrent;
		logic pump_undervoltage;
		logic motor_supply_overvoltage;
		logic motor_supply_undervoltage;
	} monitor_t;
	// Operating modes
	typedef enum logic [3:0] {
		M_SHUTDOWN = 4'h1,
		M_SLEEP = 4'h2,
		M_OPERATING = 4'h4,
		M_FAULT = 4'h8
	} mode_t;
	localparam int OC_LATCHED = 0;
	localparam logic [1:0] OC_RETRY = 2'h1;
	localparam logic [1:0] OC_REPORT = 2'h2;
	localparam logic [1:0] OC_OFF = 2'h3;
endpackage

//--- design/sync2.sv
`timescale 1ns/10ps
module sync2 import fault_mgr_pkg::*; #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ==========================================
	// Two-stage synchroniser, first stage is read only by the second
	logic [W-1:0] meta_q;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // sync2

//--- design/retry_timer.sv
`timescale 1ns/10ps
module retry_timer import fault_mgr_pkg::*; #(
	parameter int CYC = OC_RETRY_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic start,
	output logic expire
);
	// ==========================================
	// One-shot wait; a new start while running restarts the count
	logic [31:0] cnt_q;
	logic run_q;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_q <= 32'h0;
			run_q <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= run_q && (cnt_q == 32'(CYC - 1)) && !start;
			if (start) begin
				cnt_q <= 32'h0;
				run_q <= 1'b1;
			end else if (run_q) begin
				cnt_q <= cnt_q + 32'h1;
				run_q <= (cnt_q != 32'(CYC - 1));
			end
		end
	end
endmodule // retry_timer

//--- sim/mcu_model.sv
`timescale 1ns/10ps
// ==========================================
// Controller side: enable pin and the pulled-up fault line
module mcu_model (
	input wire logic ref_clk,
	input wire logic fault_pin_n_o,
	input wire logic fault_pin_n_oe,
	output logic enable_pin,
	output logic fault_line
);
	// Open-drain line, the pull-up wins whenever nobody sinks it
	assign fault_line = fault_pin_n_oe ? fault_pin_n_o : 1'b1;
	initial begin
		enable_pin = 1'b0;
	end
	// Enable changes only just after a rising edge
	task automatic set_en(input logic v);
		@(posedge ref_clk);
		enable_pin <= v;
	endtask
	// Low pulse long enough to pass the input synchroniser
	task automatic en_pulse();
		set_en(1'b0);
		repeat (8) @(posedge ref_clk);
		set_en(1'b1);
	endtask
endmodule // mcu_model

//--- sim/gate_driver_fault_manager_tb.sv
`timescale 1ns/10ps
module gate_driver_fault_manager_tb import fault_mgr_pkg::*;;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	monitor_t mon;
	mode_t mode;
	logic enable_pin, pin_o, pin_oe, block, hiz, stby, lreg, hiccup, bcl, phiz, irq, fault_line;
	logic bhiz;
	int fail_count, check_count;
	// ==========================================
	// Design and controller model
	gate_driver_fault_manager #(.RETRY_CYCLES(20)) gate_driver_fault_manager_inst (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .monitors(mon), .enable_pin(enable_pin),
		.fault_pin_n_o(pin_o), .fault_pin_n_oe(pin_oe), .gate_inputs_block(block),
		.gate_outputs_hiz(hiz), .standby_regulator_en(stby),
		.microcontroller_regulator_low_power(), .logic_regulator_en(lreg),
		.pump_en(), .pump_hiz(phiz), .buck_en(), .buck_hiz(bhiz), .buck_hiccup(hiccup),
		.buck_current_limit_en(bcl), .mode(mode), .irq(irq));
	mcu_model mcu_model_inst (.ref_clk(ref_clk), .fault_pin_n_o(pin_o),
		.fault_pin_n_oe(pin_oe), .enable_pin(enable_pin), .fault_line(fault_line));
	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) chk("pready", 1, 0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		rdchk(OFF_CTRL, 32'h0, "ctrl");
		rdchk(OFF_IRQ_MASK, 32'h0, "mask");
		rdchk(OFF_STATUS, 32'h0, "status");
		chk("mode", {28'h0, M_SLEEP}, {28'h0, mode});
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		mcu_model_inst.set_en(1'b1);
		wt(6);
		chk("mode", {28'h0, M_OPERATING}, {28'h0, mode});
		$display("test reset done");
	endtask
	// Enabled faults that block the gates, then the clear
	task automatic t_live();
		int list[7] = '{0, 1, 2, 7, 8, 9, 10};
		int i;
		logic [31:0] st;
		apb(1'b1, OFF_IRQ_MASK, 32'h7ff);
		for (int k = 0; k < 7; k++) begin
			i = list[k];
			st = (1 << i) | (1 << F_GLOBAL);
			@(posedge ref_clk) mon[i] <= 1'b1;
			wt(6);
			chk("pin", 0, fault_line);
			chk("block", 1, block);
			chk("hiz", 1, hiz);
			chk("standby", i != 2 && i != 10, stby);
			if (i != 8 && i != 9) chk("logic reg", i == 2 || i == 10, lreg);
			chk("hiccup", i == 8 || i == 9, hiccup);
			chk("pump hiz", i == 10, phiz);
			chk("buck hiz", i == 10, bhiz);
			chk("irq", 1, irq);
			chk("mode", {28'h0, M_FAULT}, {28'h0, mode});
			rdchk(OFF_STATUS, st, "status");
			@(posedge ref_clk) mon[i] <= 1'b0;
			wt(6);
			rdchk(OFF_STATUS, st, "status held");
			apb(1'b1, OFF_CTRL, 32'h1);
			apb(1'b1, OFF_IRQ_STATUS, 32'h7ff);
			wt(2);
			rdchk(OFF_STATUS, 32'h0, "status cleared");
			chk("irq", 0, irq);
			chk("pin free", 1, fault_line);
			chk("block free", 0, block);
		end
		$display("test live faults done");
	endtask
	// Thermal shutdown with detection off: report only
	task automatic t_disabled();
		apb(1'b1, OFF_CTRL, 32'h20);
		@(posedge ref_clk) mon[F_TSD] <= 1'b1;
		wt(6);
		chk("block", 0, block);
		chk("mode", {28'h0, M_OPERATING}, {28'h0, mode});
		rdchk(OFF_STATUS, (1 << F_TSD) | (1 << F_GLOBAL), "status");
		@(posedge ref_clk) mon[F_TSD] <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h21);
		rdchk(OFF_STATUS, 32'h0, "status cleared");
		$display("test disabled fault done");
	endtask
	// Every response mode of both overcurrent sources
	task automatic t_oc();
		int src;
		logic [31:0] cfg;
		for (int j = 0; j < 2; j++) begin
			for (int m = 0; m < 4; m++) begin
				src = 3 + j;
				cfg = j ? (m << 13) : (m << 11);
				apb(1'b1, OFF_CTRL, cfg);
				@(posedge ref_clk) mon[src] <= 1'b1;
				wt(6);
				chk("oc pin", m == 3, fault_line);
				chk("oc block", m < 2, block);
				@(posedge ref_clk) mon[src] <= 1'b0;
				wt(30);
				chk("oc pin held", !(m == 0 || m == 2), fault_line);
				chk("oc block held", m == 0, block);
				if (j) mcu_model_inst.en_pulse();
				else apb(1'b1, OFF_CTRL, cfg | 32'h1);
				wt(6);
				chk("oc pin free", 1, fault_line);
				rdchk(OFF_STATUS, 32'h0, "oc status");
			end
		end
		$display("test overcurrent done");
	endtask
	// Warning with and without pin report, plus buck first limit
	task automatic t_warn();
		for (int w = 0; w < 2; w++) begin
			apb(1'b1, OFF_CTRL, w << 9);
			@(posedge ref_clk);
			mon[F_WARN] <= 1'b1;
			mon.buck_current_limit <= 1'b1;
			wt(6);
			chk("warn pin", !w, fault_line);
			chk("warn block", 0, block);
			chk("current limit", 1, bcl);
			rdchk(OFF_STATUS, (1 << F_WARN) | (1 << F_GLOBAL), "warn status");
			@(posedge ref_clk);
			mon[F_WARN] <= 1'b0;
			mon.buck_current_limit <= 1'b0;
			wt(6);
			rdchk(OFF_STATUS, 32'h0, "warn status");
			chk("warn pin", 1, fault_line);
		end
		$display("test warning done");
	endtask
	// Gate stuck: latched when enabled, ignored when off
	task automatic t_stuck();
		apb(1'b1, OFF_CTRL, 32'h0);
		@(posedge ref_clk) mon[F_STUCK] <= 1'b1;
		wt(3);
		@(posedge ref_clk) mon[F_STUCK] <= 1'b0;
		wt(6);
		chk("stuck pin", 0, fault_line);
		chk("stuck block", 1, block);
		apb(1'b1, OFF_CTRL, 32'h11);
		@(posedge ref_clk) mon[F_STUCK] <= 1'b1;
		wt(6);
		chk("stuck off pin", 1, fault_line);
		chk("stuck off block", 0, block);
		@(posedge ref_clk) mon[F_STUCK] <= 1'b0;
		$display("test gate stuck done");
	endtask
	// Logic supply low, then recovery into sleep
	task automatic t_logic_uv();
		@(posedge ref_clk) mon.logic_supply_undervoltage <= 1'b1;
		wt(6);
		chk("mode", {28'h0, M_SHUTDOWN}, {28'h0, mode});
		chk("pin", 1, fault_line);
		chk("block", 1, block);
		chk("hiz", 1, hiz);
		chk("standby", 1, stby);
		chk("logic reg", 0, lreg);
		mcu_model_inst.set_en(1'b0);
		mon.logic_supply_undervoltage <= 1'b0;
		wt(6);
		chk("mode", {28'h0, M_SLEEP}, {28'h0, mode});
		$display("test logic supply done");
	endtask
	// ==========================================
	// Clock, watchdog and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Whole run is under a thousand cycles, so this only fires on a hang
	initial begin
		#200000;
		fail_count++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		fail_count = 0;
		check_count = 0;
		sys_rst = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		mon = '0;
		mon.soft_start_done = 1'b1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		wt(3);
		t_reset();
		t_live();
		t_disabled();
		t_oc();
		t_warn();
		t_stuck();
		t_logic_uv();
		tally_and_finish();
	end
endmodule // gate_driver_fault_manager_tb
